// ---- common/trip_interlock_pkg.sv ----
// Constants and types shared by the power stage trip interlock
package trip_interlock_pkg;
    localparam int N_DIG = 3;
    localparam int N_ANA = 3;
    localparam int CNT_W = 16;
    localparam logic [15:0] PERIOD_RST = 16'h03e7;
    localparam int N_PWM = 6;
    // Register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_DIG_REACT = 8'h04;
    localparam logic [7:0] REG_ANA_REACT = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_IRQ_STAT = 8'h10;
    localparam logic [7:0] REG_IRQ_MASK = 8'h14;
    localparam logic [7:0] REG_PERIOD = 8'h18;
    // Control fields
    localparam int CTRL_PIN_EN = 0;
    localparam int CTRL_PIN_POL = 1;
    localparam int CTRL_SAFE_FLOAT = 2;
    localparam int CTRL_PRESENT = 3;
    localparam logic [3:0] CTRL_RST = 4'h8;
    // Reaction codes
    localparam logic [1:0] REACT_NONE = 2'h0;
    localparam logic [1:0] REACT_OSHT = 2'h1;
    localparam logic [1:0] REACT_CBC = 2'h2;
    // Interrupt status bits
    localparam int IRQ_OSHT = 0;
    localparam int IRQ_CBC = 1;
    localparam int IRQ_ENABLED = 2;
    localparam int IRQ_UNDER = 3;
    localparam int IRQ_W = 4;
    typedef enum logic [1:0] {CARRIER_UP, CARRIER_DOWN} dir_e;
endpackage

// ---- rtl/carrier_counter.sv ----
// Symmetric up/down PWM carrier with underflow and overflow pulses
`timescale 1ns/1ps
`default_nettype none
module carrier_counter
    import trip_interlock_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [CNT_W-1:0] period,
    output logic [CNT_W-1:0] count,
    output logic underflow,
    output logic overflow
);
    dir_e dir_r;
    logic [CNT_W-1:0] cnt_r;

    assign count = cnt_r;
    assign underflow = (cnt_r == '0) && (dir_r == CARRIER_DOWN);
    assign overflow = (cnt_r >= period) && (dir_r == CARRIER_UP);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_r <= '0;
            dir_r <= CARRIER_UP;
        end else begin
            case (dir_r)
                CARRIER_UP: begin
                    if (cnt_r >= period) begin
                        dir_r <= CARRIER_DOWN;
                        cnt_r <= (cnt_r == '0) ? cnt_r : cnt_r - 1'b1;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                CARRIER_DOWN: begin
                    if (cnt_r == '0) begin
                        dir_r <= CARRIER_UP;
                        cnt_r <= (period == '0) ? cnt_r : cnt_r + 1'b1;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                default: begin
                    dir_r <= CARRIER_UP;
                    cnt_r <= '0;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- rtl/powerstage_trip_interlock.sv ----
// Power stage interlock gating all PWM outputs, with digital and analog trips
// Notes on behaviour
// - PWM outputs stay off from reset until an enable request rising edge.
// - On enable rising edge, status pin goes 0 (active low) or 1 (high).
// - Status pin only reports state; gating is the same configured or not.
// - Without the interlock present, PWM outputs pass ungated permanently.
// - A low level on a digital trip input is a trip; high is no trip.
// - Each digital trip input has reaction none, one-shot or cycle-by-cycle.
// - A digital one-shot trip latches safe state until disable then enable.
// - Cycle-by-cycle trip holds until underflow, clearing there if input high.
// - Analog trip signals A, B, C each react with none or one-shot.
// - An analog one-shot trip latches safe state until disable then enable.
// - Safe state is forced passive level or high impedance, selectable.
// - Underflow pulses at carrier minimum, overflow at carrier maximum.
`timescale 1ns/1ps
`default_nettype none
module powerstage_trip_interlock
    import trip_interlock_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable_req,
    input wire logic digital_trip_input_1_n,
    input wire logic digital_trip_input_2_n,
    input wire logic digital_trip_input_3_n,
    input wire logic [N_ANA-1:0] analog_trip,
    input wire logic [N_PWM-1:0] pwm_in,
    input wire logic [N_PWM-1:0] pwm_passive,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic [N_PWM-1:0] pwm_out,
    output logic [N_PWM-1:0] pwm_oe,
    output logic stage_enable_pin,
    output logic stage_enable_pin_oe,
    output logic underflow,
    output logic overflow,
    output logic irq
);
    logic [3:0] ctrl_r;
    logic [2*N_DIG-1:0] dig_react_r;
    logic [2*N_ANA-1:0] ana_react_r;
    logic [CNT_W-1:0] period_r;
    logic [IRQ_W-1:0] irq_stat_r;
    logic [IRQ_W-1:0] irq_mask_r;
    logic [31:0] rdata_r;
    logic en_prev_r;
    logic enabled_r;
    logic osht_r;
    logic cbc_r;
    logic [N_PWM-1:0] pwm_out_r;
    logic [N_PWM-1:0] pwm_oe_r;
    logic pin_r;
    logic [CNT_W-1:0] count;
    logic [N_DIG-1:0] dig_trip;
    logic [N_DIG-1:0] dig_osht_hit;
    logic [N_DIG-1:0] dig_cbc_hit;
    logic [N_ANA-1:0] ana_osht_hit;
    logic en_rise;
    logic en_fall;
    logic osht_any;
    logic cbc_any;
    logic tripped;
    logic gate_open;
    logic [IRQ_W-1:0] irq_events;
    logic wr_stat;

    carrier_counter u_carrier (
        .clk(clk),
        .rst_n(rst_n),
        .period(period_r),
        .count(count),
        .underflow(underflow),
        .overflow(overflow)
    );

    // Trip inputs are active low
    assign dig_trip = ~{digital_trip_input_3_n, digital_trip_input_2_n,
                        digital_trip_input_1_n};

    genvar gi;
    generate
        for (gi = 0; gi < N_DIG; gi++) begin : g_dig
            assign dig_osht_hit[gi] = dig_trip[gi]
                && (dig_react_r[2*gi+:2] == REACT_OSHT);
            assign dig_cbc_hit[gi] = dig_trip[gi]
                && (dig_react_r[2*gi+:2] == REACT_CBC);
        end
        for (gi = 0; gi < N_ANA; gi++) begin : g_ana
            // Analog signals only know none or one-shot; other codes act as none
            assign ana_osht_hit[gi] = analog_trip[gi]
                && (ana_react_r[2*gi+:2] == REACT_OSHT);
        end
    endgenerate

    assign en_rise = enable_req && !en_prev_r;
    assign en_fall = !enable_req && en_prev_r;
    assign osht_any = (|dig_osht_hit) || (|ana_osht_hit);
    assign cbc_any = |dig_cbc_hit;
    assign tripped = osht_r || osht_any || cbc_r || cbc_any;
    assign gate_open = enabled_r && !tripped;

    // Tracks the request during reset too, so a level held high is never an edge
    always_ff @(posedge clk) begin
        en_prev_r <= enable_req;
    end

    // Only a rising edge releases; a request held high through reset does nothing
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            enabled_r <= 1'b0;
        end else if (en_rise) begin
            enabled_r <= 1'b1;
        end else if (en_fall) begin
            enabled_r <= 1'b0;
        end
    end

    // One-shot latch: cleared only when the interlock is re-enabled
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            osht_r <= 1'b0;
        end else if (osht_any) begin
            osht_r <= 1'b1;
        end else if (en_rise && !enabled_r) begin
            osht_r <= 1'b0;
        end
    end

    // Cycle-by-cycle: released only at underflow with input no longer low
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cbc_r <= 1'b0;
        end else if (cbc_any) begin
            cbc_r <= 1'b1;
        end else if (underflow) begin
            cbc_r <= 1'b0;
        end
    end

    // Output gating never looks at the status pin configuration
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pwm_out_r <= '0;
            pwm_oe_r <= '0;
        end else if (!ctrl_r[CTRL_PRESENT]) begin
            pwm_out_r <= pwm_in;
            pwm_oe_r <= '1;
        end else if (gate_open) begin
            pwm_out_r <= pwm_in;
            pwm_oe_r <= '1;
        end else if (ctrl_r[CTRL_SAFE_FLOAT]) begin
            pwm_out_r <= '0;
            pwm_oe_r <= '0;
        end else begin
            pwm_out_r <= pwm_passive;
            pwm_oe_r <= '1;
        end
    end
    assign pwm_out = pwm_out_r;
    assign pwm_oe = pwm_oe_r;

    // Status pin mirrors enabled and untripped state in the chosen polarity
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_r <= 1'b0;
        end else begin
            pin_r <= ctrl_r[CTRL_PIN_POL] ? gate_open : !gate_open;
        end
    end
    assign stage_enable_pin = ctrl_r[CTRL_PIN_EN] ? pin_r : 1'b0;
    assign stage_enable_pin_oe = ctrl_r[CTRL_PIN_EN];

    // Configuration writes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_r <= CTRL_RST;
            dig_react_r <= '0;
            ana_react_r <= '0;
            period_r <= PERIOD_RST;
            irq_mask_r <= '0;
        end else if (reg_wr) begin
            case (reg_addr)
                REG_CTRL: ctrl_r <= reg_wdata[3:0];
                REG_DIG_REACT: dig_react_r <= reg_wdata[2*N_DIG-1:0];
                REG_ANA_REACT: ana_react_r <= reg_wdata[2*N_ANA-1:0];
                REG_PERIOD: period_r <= reg_wdata[CNT_W-1:0];
                REG_IRQ_MASK: irq_mask_r <= reg_wdata[IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // Sticky events; a new event wins over a write-one-to-clear
    assign irq_events = {underflow, en_rise, cbc_any, osht_any};
    assign wr_stat = reg_wr && (reg_addr == REG_IRQ_STAT);
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~(wr_stat ? reg_wdata[IRQ_W-1:0] : '0))
                | irq_events;
        end
    end
    assign irq = |(irq_stat_r & irq_mask_r);

    // Read data one cycle after the strobe, zero otherwise and for unmapped offsets
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_r <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                REG_CTRL: rdata_r <= {28'h0000000, ctrl_r};
                REG_DIG_REACT: rdata_r <= {26'h0, dig_react_r};
                REG_ANA_REACT: rdata_r <= {26'h0, ana_react_r};
                REG_STATUS: rdata_r <= {count, 11'h000, gate_open, cbc_r,
                                        osht_r, enabled_r, pin_r};
                REG_IRQ_STAT: rdata_r <= {28'h0000000, irq_stat_r};
                REG_IRQ_MASK: rdata_r <= {28'h0000000, irq_mask_r};
                REG_PERIOD: rdata_r <= {16'h0000, period_r};
                default: rdata_r <= '0;
            endcase
        end else begin
            rdata_r <= '0;
        end
    end
    assign reg_rdata = rdata_r;
endmodule
`default_nettype wire

// ---- verification/interlock_monitor.sv ----
// Checker for interlock gating, trip latching and carrier event pulses
`timescale 1ns/1ps
`default_nettype none
module interlock_monitor
    import trip_interlock_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable_req,
    input wire logic digital_trip_input_1_n,
    input wire logic digital_trip_input_2_n,
    input wire logic digital_trip_input_3_n,
    input wire logic [N_ANA-1:0] analog_trip,
    input wire logic [N_PWM-1:0] pwm_passive,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [N_PWM-1:0] pwm_out,
    input wire logic [N_PWM-1:0] pwm_oe,
    input wire logic stage_enable_pin,
    input wire logic stage_enable_pin_oe,
    input wire logic underflow,
    input wire logic overflow
);
    logic en_d_r, en_r, os_r, os_src, trip_any, closed, pres;
    logic [3:0] ctrl_r;
    logic [5:0] dig_r, ana_r;
    logic [2:0] lo, d_os, d_any, a_os;
    logic [N_PWM-1:0] pass_d_r;
    assign lo = ~{digital_trip_input_3_n, digital_trip_input_2_n, digital_trip_input_1_n};
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            d_os[i] = dig_r[2*i+:2] == REACT_OSHT;
            d_any[i] = d_os[i] || dig_r[2*i+:2] == REACT_CBC;
            a_os[i] = ana_r[2*i+:2] == REACT_OSHT;
        end
    end
    assign os_src = |(lo & d_os) || |(analog_trip & a_os);
    assign trip_any = os_src || |(lo & d_any);
    assign pres = ctrl_r[CTRL_PRESENT];
    assign closed = pwm_oe == '0 || (pwm_oe == '1 && pwm_out == pass_d_r);
    // Passive level as the design last sampled it, since outputs lag one cycle
    always_ff @(posedge clk) begin
        pass_d_r <= pwm_passive;
    end
    // Shadow of the set-up, so trips are judged against the live reactions
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_r <= CTRL_RST;
            dig_r <= '0;
            ana_r <= '0;
        end else if (reg_wr && reg_addr == REG_CTRL) begin
            ctrl_r <= reg_wdata[3:0];
        end else if (reg_wr && reg_addr == REG_DIG_REACT) begin
            dig_r <= reg_wdata[5:0];
        end else if (reg_wr && reg_addr == REG_ANA_REACT) begin
            ana_r <= reg_wdata[5:0];
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            en_d_r <= enable_req;
            en_r <= 1'b0;
            os_r <= 1'b0;
        end else begin
            en_d_r <= enable_req;
            en_r <= enable_req && (en_r || !en_d_r);
            os_r <= os_src || (os_r && !(enable_req && !en_d_r));
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Three cycles of cause cover the one-cycle output latency
    sequence trip_held;
        (trip_any && pres)[*3];
    endsequence
    sequence latched(bit f);
        (os_r && pres && ctrl_r[CTRL_SAFE_FLOAT] == f)[*3];
    endsequence
    chk_uf_of_apart: assert property (underflow |-> !overflow)
        else $error("underflow and overflow together");
    chk_uf_one_cycle: assert property (underflow |=> !underflow)
        else $error("underflow pulse too long");
    chk_of_then_uf: assert property (overflow |-> ##[1:1000] underflow)
        else $error("no underflow after overflow");
    chk_off_until_rise: assert property (!en_r && !$past(en_r) && pres && $past(pres) |-> closed)
        else $error("outputs open without enable edge");
    chk_pin_quiet: assert property (!stage_enable_pin_oe |-> !stage_enable_pin)
        else $error("status pin active while not configured");
    chk_trip_closes: assert property (trip_held |-> closed)
        else $error("outputs open during trip");
    chk_latch_float: assert property (latched(1'b1) |-> pwm_oe == '0)
        else $error("latched trip not floating");
    chk_latch_forced: assert property (latched(1'b0) |-> pwm_oe == '1 && pwm_out == pass_d_r)
        else $error("latched trip not at passive level");
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
        else $error("read data outside read slot");
endmodule
bind powerstage_trip_interlock interlock_monitor i_mon (.clk, .rst_n, .enable_req,
    .digital_trip_input_1_n, .digital_trip_input_2_n, .digital_trip_input_3_n, .analog_trip,
    .pwm_passive, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pwm_out, .pwm_oe,
    .stage_enable_pin, .stage_enable_pin_oe, .underflow, .overflow);
`default_nettype wire

// ---- verification/powerstage_trip_interlock_bench.sv ----
// Self-checking bench for the power stage trip interlock
`timescale 1ns/1ps
`default_nettype none
module powerstage_trip_interlock_bench
    import trip_interlock_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, enable_req = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [2:0] trip_n = '1, analog_trip = '0;
    logic [5:0] pwm_in, pwm_passive = '0, pwm_out, pwm_oe;
    logic [7:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0, reg_rdata, v;
    logic stage_enable_pin, stage_enable_pin_oe, underflow, overflow, irq;
    int bad_count = 0, total_checks = 0, cyc = 0, fl = 0, k, n, s, c, osh;
    powerstage_trip_interlock i_dut (.clk, .rst_n, .enable_req,
        .digital_trip_input_1_n(trip_n[0]), .digital_trip_input_2_n(trip_n[1]),
        .digital_trip_input_3_n(trip_n[2]), .analog_trip, .pwm_in, .pwm_passive, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pwm_out, .pwm_oe, .stage_enable_pin,
        .stage_enable_pin_oe, .underflow, .overflow, .irq);
    pwm_gen_model i_gen (.clk, .rst_n, .underflow, .overflow, .pwm_in);
    always #10 clk = ~clk;
    task automatic tally_and_finish;
        if (bad_count == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic ok, input string m);
        total_checks++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk) reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk) reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk) reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk) reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic wait_ev(input int of, output int cnt);
        cnt = 0;
        do begin
            @(negedge clk);
            cnt++;
        end while ((of ? overflow : underflow) !== 1'b1 && cnt < 2100);
    endtask
    // Compare a few cycles after an underflow, clear of pattern changes
    task automatic sync;
        wait_ev(0, n);
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic chk_out(input int open);
        if (open) chk(pwm_out === pwm_in && pwm_oe === '1, "gate not open");
        else if (fl) chk(pwm_oe === '0, "not floating");
        else chk(pwm_oe === '1 && pwm_out === pwm_passive, "not passive");
    endtask
    task automatic chk_off;
        chk(pwm_oe === '0 || (pwm_oe === '1 && pwm_out === pwm_passive), "not off");
    endtask
    task automatic rearm;
        @(posedge clk) enable_req <= 1'b0;
        @(posedge clk) enable_req <= 1'b1;
    endtask
    initial begin
        v = $urandom(82887);
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        reg_read(REG_CTRL, v);
        chk(v === 32'h8, "ctrl reset");
        reg_read(REG_PERIOD, v);
        chk(v === {16'h0, PERIOD_RST}, "period reset");
        reg_write(REG_PERIOD, 32'h9);
        reg_write(8'h1c, '1);
        reg_read(8'h1c, v);
        chk(v === '0, "unmapped read");
        sync;
        chk_off();
        wait_ev(1, n);
        wait_ev(0, n);
        chk(n == 9, "overflow to underflow");
        wait_ev(1, n);
        chk(n == 9, "underflow to overflow");
        for (k = 0; k < 3; k++) begin
            reg_write(REG_CTRL, 32'h8 | (k > 0) | ((k == 2) << 1));
            rearm();
            sync;
            chk_out(1);
            if (k > 0) chk(stage_enable_pin === (k == 2) && stage_enable_pin_oe === 1'b1, "pin on");
            else chk(!stage_enable_pin && !stage_enable_pin_oe, "pin idle");
            @(posedge clk) enable_req <= 1'b0;
            sync;
            chk_off();
            if (k > 0) chk(stage_enable_pin === (k != 2), "pin off");
        end
        reg_write(REG_IRQ_MASK, 32'h1 << IRQ_OSHT);
        for (k = 0; k < 18; k++) begin
            s = k / 3;
            c = k % 3;
            fl = k % 2;
            osh = c == 1;
            @(posedge clk) pwm_passive <= 6'($urandom);
            reg_write(REG_CTRL, 32'h8 | (fl << CTRL_SAFE_FLOAT));
            reg_write(s < 3 ? REG_DIG_REACT : REG_ANA_REACT, c << (2 * (s % 3)));
            rearm();
            @(posedge clk) if (s < 3) trip_n[s] <= 1'b0; else analog_trip[s-3] <= 1'b1;
            sync;
            chk_out(s < 3 ? c == 0 : !osh);
            chk(irq === (osh != 0), "irq level");
            reg_read(REG_STATUS, v);
            chk(v[2] === (osh != 0), "latch status");
            @(posedge clk) trip_n <= '1;
            analog_trip <= '0;
            // Still before the next underflow, so a cycle-by-cycle trip must hold
            repeat (3) @(posedge clk);
            #1 chk_out(s < 3 ? c == 0 : !osh);
            sync;
            chk_out(!osh);
            reg_write(REG_IRQ_STAT, 32'h1 << IRQ_OSHT);
            #1 chk(irq === 1'b0, "irq clear");
            rearm();
            sync;
            chk_out(1);
        end
        // A request held high through a reset is no edge: outputs must stay off
        @(posedge clk) enable_req <= 1'b1;
        rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        reg_write(REG_PERIOD, 32'h9);
        sync;
        chk_off();
        chk(irq === 1'b0, "irq after reset");
        @(posedge clk) enable_req <= 1'b0;
        reg_write(REG_CTRL, 32'h0);
        sync;
        chk_out(1);
        tally_and_finish();
    end
endmodule
`default_nettype wire

// ---- verification/pwm_gen_model.sv ----
// PWM generator stand-in that changes its pattern only at carrier events
`timescale 1ns/1ps
`default_nettype none
module pwm_gen_model
    import trip_interlock_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic underflow,
    input wire logic overflow,
    output logic [N_PWM-1:0] pwm_in
);
    // Quiet between events, so gated outputs can be compared mid-cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pwm_in <= 6'h15;
        end else if (underflow || overflow) begin
            pwm_in <= {pwm_in[N_PWM-2:0], ~pwm_in[N_PWM-1]};
        end
    end
endmodule
`default_nettype wire
